// ---- hw/eemi_regs.vh ----
// Register offsets, field positions, reset values and timing counts of the encoder emulation block
`ifndef EEMI_REGS_VH
`define EEMI_REGS_VH
`define EEMI_ADDR_W 6
`define EEMI_OFF_CTRL 6'h00
`define EEMI_OFF_RES 6'h04
`define EEMI_OFF_LINES 6'h08
`define EEMI_OFF_RATIO 6'h0C
`define EEMI_OFF_POS 6'h10
`define EEMI_OFF_REF 6'h14
`define EEMI_OFF_STAT 6'h18
`define EEMI_CTRL_FUNC 0
`define EEMI_CTRL_STEP 1
`define EEMI_CTRL_HTL 2
`define EEMI_CTRL_RESOLVER 3
`define EEMI_CTRL_NOZERO 4
`define EEMI_CTRL_RST 32'h00000000
`define EEMI_RES_RST 16'h0800
`define EEMI_LINES_RST 16'h0800
`define EEMI_RATIO_RST 16'h0100
`define EEMI_RATIO_FRAC 8
`define EEMI_CLK_HZ 200000000
`define EEMI_FMAX_HZ 500000
`define EEMI_EDGE_CYC ((`EEMI_CLK_HZ / (`EEMI_FMAX_HZ * 4)) > 1 ? (`EEMI_CLK_HZ / (`EEMI_FMAX_HZ * 4)) : 1)
`define EEMI_RESP_OKAY 2'b00
`define EEMI_RESP_SLVERR 2'b10
`endif

// ---- hw/eemi_top.v ----
// Encoder emulation output and master reference input with an AXI4-Lite register slave
`include "eemi_regs.vh"

// Function
// - Port runs either emulation output or master reference input, never both.
// - Emulation derives quadrature A/B and zero pulse R from motor position.
// - Resolver feedback: emulated lines per revolution come from a setting.
// - Incremental feedback: emulated resolution equals connected encoder resolution.
// - Master input pulses become the loop position reference.
// - Master input decodes A/B quadrature or pulse plus direction by setting.
// - Settings: signal type, source lines per revolution, transmission ratio.
// - Alternative master encoder on general inputs three and four.
// - Digital-input master path disables emulation output and port master input.
// - Logic-level rotary encoder accepted on port master input.
module eemi_top (
  input wire aclk,
  input wire aresetn,
  input wire [5:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] motor_pos,
  input wire [15:0] feedback_lines,
  input wire port_in_a,
  input wire port_in_b,
  input wire general_input_three,
  input wire general_input_four,
  output reg emu_a,
  output reg emu_b,
  output reg emu_r,
  output reg emu_oe,
  output reg [31:0] ref_pos
);

  // Pacing count is an integer expression; only its low byte is kept for the 8-bit counter
  localparam integer EDGE_CYC_I = `EEMI_EDGE_CYC;
  localparam [7:0] EDGE_CYC = EDGE_CYC_I[7:0];

  // Configuration registers
  reg [31:0] ctrl_r;
  reg [15:0] res_r;
  reg [15:0] lines_r;
  reg [15:0] ratio_r;
  // Write halves held until the response goes out
  reg aw_got_r;
  reg w_got_r;
  reg [5:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  // Emulation tracker: target and emitted edge counts, pacing, phase
  reg [31:0] emu_cnt_r;
  reg [31:0] emu_tgt_r;
  reg [7:0] pace_r;
  reg [1:0] emu_ph_r;
  reg [15:0] prev_pos_r;
  // Master input: previous source sample, raw count, scaled product
  reg [1:0] in_ab_prev_r;
  reg [31:0] raw_cnt_r;
  reg [31:0] mul_r;
  reg busy_r;

  // Control fields; the digital-input path wins over both port functions
  wire func_master = ctrl_r[`EEMI_CTRL_FUNC];
  wire sig_step = ctrl_r[`EEMI_CTRL_STEP];
  wire htl_sel = ctrl_r[`EEMI_CTRL_HTL];
  wire fb_resolver = ctrl_r[`EEMI_CTRL_RESOLVER];
  wire fb_nozero = ctrl_r[`EEMI_CTRL_NOZERO];
  wire emu_on = !func_master && !htl_sel;
  wire port_in_on = func_master && !htl_sel;

  // Write channel: address and data accepted in either order, response after both
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  // A read is refused while its answer is still pending
  assign s_axi_arready = !s_axi_rvalid;

  // Byte-lane merge so partial writes keep the untouched lanes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Merged write values and the address hit used for the response code
  wire [31:0] ctrl_m = merge(ctrl_r, wdata_r, wstrb_r);
  wire [31:0] res_m = merge({16'h0000, res_r}, wdata_r, wstrb_r);
  wire [31:0] lines_m = merge({16'h0000, lines_r}, wdata_r, wstrb_r);
  wire [31:0] ratio_m = merge({16'h0000, ratio_r}, wdata_r, wstrb_r);
  wire wr_hit = (awaddr_r == `EEMI_OFF_CTRL) || (awaddr_r == `EEMI_OFF_RES) ||
                (awaddr_r == `EEMI_OFF_LINES) || (awaddr_r == `EEMI_OFF_RATIO);

  // Bus slave and configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 6'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EEMI_RESP_OKAY;
      ctrl_r <= `EEMI_CTRL_RST;
      res_r <= `EEMI_RES_RST;
      lines_r <= `EEMI_LINES_RST;
      ratio_r <= `EEMI_RATIO_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      // Commit once both halves are held; the response rises on the same edge
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `EEMI_RESP_OKAY : `EEMI_RESP_SLVERR;
        case (awaddr_r)
          `EEMI_OFF_CTRL: begin
            ctrl_r <= {27'h0000000, ctrl_m[4:0]};
          end
          `EEMI_OFF_RES: begin
            res_r <= res_m[15:0];
          end
          `EEMI_OFF_LINES: begin
            lines_r <= lines_m[15:0];
          end
          `EEMI_OFF_RATIO: begin
            ratio_r <= ratio_m[15:0];
          end
          default: begin
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EEMI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EEMI_RESP_OKAY;
      case ({s_axi_araddr[5:2], 2'b00})
        `EEMI_OFF_CTRL: s_axi_rdata <= ctrl_r;
        `EEMI_OFF_RES: s_axi_rdata <= {16'h0000, res_r};
        `EEMI_OFF_LINES: s_axi_rdata <= {16'h0000, lines_r};
        `EEMI_OFF_RATIO: s_axi_rdata <= {16'h0000, ratio_r};
        `EEMI_OFF_POS: s_axi_rdata <= raw_cnt_r;
        `EEMI_OFF_REF: s_axi_rdata <= ref_pos;
        // Status: catching up, output enable, port input on, emulation on
        `EEMI_OFF_STAT: s_axi_rdata <= {28'h0000000, busy_r, emu_oe, port_in_on, emu_on};
        // Unmapped offsets answer with an error and zero data
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `EEMI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Emulation: target edge count tracks motor position scaled to lines per revolution
  wire [15:0] emu_lines = fb_resolver ? res_r : feedback_lines;
  wire [15:0] pos_delta = motor_pos - prev_pos_r;
  wire [31:0] delta_sx = {{16{pos_delta[15]}}, pos_delta};
  wire [47:0] tgt_step = $signed(delta_sx) * $signed({16'h0000, emu_lines, 2'b00});
  wire [31:0] tgt_inc = tgt_step[47:16]; // Fraction dropped: error stays under one edge per step
  wire [33:0] rev_edges = {16'h0000, emu_lines, 2'b00};
  wire signed [31:0] emu_err = emu_tgt_r - emu_cnt_r;
  // Zero test uses the previous sample, so the pulse stands two cycles behind the shaft
  wire at_zero = (prev_pos_r == 16'h0000);

  // Quadrature output; edges paced so the rate never exceeds the receiver limit
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_pos_r <= 16'h0000;
      emu_tgt_r <= 32'h00000000;
      emu_cnt_r <= 32'h00000000;
      emu_ph_r <= 2'b00;
      pace_r <= 8'h00;
      emu_a <= 1'b0;
      emu_b <= 1'b0;
      emu_r <= 1'b0;
      emu_oe <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      prev_pos_r <= motor_pos;
      emu_oe <= emu_on;
      // Target follows the shaft every cycle, whichever function is selected
      emu_tgt_r <= emu_tgt_r + tgt_inc;
      busy_r <= (emu_err != 32'h00000000);
      // While off, the count stays aligned and the phase parks at 00: enabling later emits no backlog burst
      if (!emu_on) begin
        emu_cnt_r <= emu_tgt_r + tgt_inc;
        emu_ph_r <= 2'b00;
        pace_r <= 8'h00;
      end else if (pace_r != 8'h00) begin
        pace_r <= pace_r - 8'h01;
      end else if (emu_on && emu_err > 0) begin
        emu_cnt_r <= emu_cnt_r + 32'h00000001;
        emu_ph_r <= emu_ph_r + 2'b01;
        pace_r <= EDGE_CYC - 8'h01;
      end else if (emu_on && emu_err < 0) begin
        emu_cnt_r <= emu_cnt_r - 32'h00000001;
        emu_ph_r <= emu_ph_r - 2'b01;
        pace_r <= EDGE_CYC - 8'h01;
      end
      // Gray sequence 00,10,11,01: A leads B forward, B leads A in reverse
      emu_a <= emu_on & (emu_ph_r == 2'b01 || emu_ph_r == 2'b10);
      emu_b <= emu_on & emu_ph_r[1];
      emu_r <= emu_on & !fb_nozero & at_zero & (rev_edges != 34'h0);
    end
  end

  // Master input source: digital-input pair overrides the port
  wire [1:0] src_ab = htl_sel ? {general_input_three, general_input_four} :
                      (port_in_on ? {port_in_a, port_in_b} : 2'b00);
  // Counting runs only while a master source is selected
  wire src_on = htl_sel || port_in_on;
  // Decoded step of this cycle: +1, -1 or 0
  reg [31:0] step_val;

  // Decode quadrature or pulse plus direction into signed counts
  always @* begin
    step_val = 32'h00000000;
    if (sig_step) begin
      if (src_ab[1] && !in_ab_prev_r[1]) begin
        step_val = src_ab[0] ? 32'hFFFFFFFF : 32'h00000001;
      end
    end else begin
      case ({in_ab_prev_r, src_ab})
        4'b0010, 4'b1011, 4'b1101, 4'b0100: step_val = 32'h00000001;
        4'b0001, 4'b0111, 4'b1110, 4'b1000: step_val = 32'hFFFFFFFF;
        default: step_val = 32'h00000000;
      endcase
    end
  end

  // Scale raw counts into the reference: counts times ratio over lines, fixed point
  wire [63:0] scaled = $signed(raw_cnt_r) * $signed({16'h0000, ratio_r});
  // Drop the eight fraction bits of the ratio
  wire [47:0] ref_full = scaled[55:8];

  always @(posedge aclk) begin
    if (!aresetn) begin
      in_ab_prev_r <= 2'b00;
      raw_cnt_r <= 32'h00000000;
      mul_r <= 32'h00000000;
      ref_pos <= 32'h00000000;
    end else begin
      // Previous source sample for edge detection
      in_ab_prev_r <= src_ab;
      if (src_on) begin
        raw_cnt_r <= raw_cnt_r + step_val;
      end
      // Lines register sets the count base; a zero value holds the reference still
      mul_r <= ref_full[31:0];
      if (lines_r != 16'h0000) begin
        ref_pos <= $signed(mul_r) / $signed({16'h0000, lines_r});
      end
    end
  end

endmodule // eemi_top

// ---- test/eemi_top_properties.sv ----
// Port-level properties of the encoder emulation block
module eemi_top_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [15:0] motor_pos,
  input wire emu_a,
  input wire emu_b,
  input wire emu_r,
  input wire emu_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken on one edge
  sequence wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Any emulated line edge
  sequence emu_edge_s;
    $changed(emu_a) || $changed(emu_b);
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
  // Both halves are registered first, so the response stands from the second edge on
  wr_answer_a: assert property (wr_both_s |-> ##2 s_axi_bvalid) else $error("no write answer");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  quad_gray_a: assert property ($changed(emu_a) |-> $stable(emu_b)) else $error("A and B moved together");
  // Edges are paced far apart so the receiver never sees more than the line rate
  edge_pace_a: assert property (emu_edge_s |=> ($stable({emu_a, emu_b}))[*8]) else $error("edges too close");
  zero_pos_a: assert property (emu_r |-> $past(motor_pos) == 16'h0000 || $past(motor_pos, 2) == 16'h0000)
    else $error("zero pulse off position");
  zero_oe_a: assert property (emu_r |-> emu_oe) else $error("zero pulse without emulation");
endmodule // eemi_top_properties

bind eemi_top eemi_top_properties chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .motor_pos,
  .emu_a, .emu_b, .emu_r, .emu_oe);

// ---- test/eemi_ctrl_model.sv ----
// Far-side controller model: counts emulated edges and sends master pulses
module eemi_ctrl_model (
  input wire aclk,
  input wire emu_a,
  input wire emu_b,
  input wire req,
  input wire pd_mode,
  input wire rev,
  output wire out_a,
  output wire out_b,
  output logic [31:0] edge_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic qa_r = 1'b0;
  logic qb_r = 1'b0;
  logic [1:0] ph_r = 2'b00;
  initial edge_count = 32'h00000000;
  // Counts every edge when sampled, so it keeps up with the full line rate
  always @(posedge aclk) begin
    qa_r <= emu_a;
    qb_r <= emu_b;
    if (emu_a != qa_r) edge_count <= edge_count + ((emu_a ^ qb_r) ? 32'h00000001 : 32'hFFFFFFFF);
    if (emu_b != qb_r) edge_count <= edge_count + ((emu_b ^ qa_r) ? 32'hFFFFFFFF : 32'h00000001);
    if (req && !pd_mode) ph_r <= rev ? ph_r - 2'h1 : ph_r + 2'h1;
  end
  // A leads B going forward; in pulse mode B is direction, high for reverse
  assign out_a = pd_mode ? req : ph_r[1] ^ ph_r[0];
  assign out_b = pd_mode ? rev : ph_r[1];
endmodule // eemi_ctrl_model

// ---- test/eemi_top_bench.sv ----
// Self-checking bench of the encoder emulation and master input block
`include "eemi_regs.vh"
module eemi_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic req = 1'b0, pd = 1'b0, rev = 1'b0, via_gen = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000, rd_d, e0;
  logic [15:0] motor_pos = 16'h0000, fb_lines = 16'h0008;
  logic [1:0] rd_s, wr_s;
  wire awready, wready, bvalid, arready, rvalid, ea, eb, er, eoe, pa, pb;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, ref_pos, edges;
  integer num_errors = 0, check_count = 0, i;
  // Register address, reset read value, response
  logic [39:0] rows [8] = '{{`EEMI_OFF_CTRL, 32'h00000000, `EEMI_RESP_OKAY}, {`EEMI_OFF_RES, 32'h00000800, 2'b00},
    {`EEMI_OFF_LINES, 32'h00000800, 2'b00}, {`EEMI_OFF_RATIO, 32'h00000100, 2'b00}, {`EEMI_OFF_POS, 32'h0, 2'b00},
    {`EEMI_OFF_REF, 32'h0, 2'b00}, {6'h1C, 32'h0, `EEMI_RESP_SLVERR}, {6'h3C, 32'h0, `EEMI_RESP_SLVERR}};
  eemi_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .motor_pos(motor_pos), .feedback_lines(fb_lines), .port_in_a(pa & !via_gen),
    .port_in_b(pb & !via_gen), .general_input_three(pa & via_gen), .general_input_four(pb & via_gen),
    .emu_a(ea), .emu_b(eb), .emu_r(er), .emu_oe(eoe), .ref_pos(ref_pos));
  eemi_ctrl_model far_u (.aclk(aclk), .emu_a(ea), .emu_b(eb), .req(req), .pd_mode(pd), .rev(rev),
    .out_a(pa), .out_b(pb), .edge_count(edges));
  initial forever #2.5 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Each channel is released at the edge where it is taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr_s = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_d = rdata;
    rd_s = rresp;
    rready <= 1'b0;
  endtask
  // One step every 402 cycles keeps the source well under the input limit
  task automatic send(input int n);
    repeat (n) begin
      @(posedge aclk);
      req <= 1'b1;
      @(posedge aclk);
      req <= 1'b0;
      repeat (400) @(posedge aclk);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(rows[i][39:34]);
      chk(rd_d, rows[i][33:2]);
      chk(rd_s, rows[i][1:0]);
    end
    wr(6'h1C, 32'h00000001);
    chk(wr_s, `EEMI_RESP_SLVERR);
    // Quadrature master, one line, ratio two
    wr(`EEMI_OFF_LINES, 32'h00000001);
    wr(`EEMI_OFF_RATIO, 32'h00000200);
    wr(`EEMI_OFF_CTRL, 32'h00000001);
    send(12);
    rd(`EEMI_OFF_POS);
    chk(rd_d, 32'h0000000C);
    chk(ref_pos, 32'h00000018);
    chk(eoe, 1'b0);
    rev <= 1'b1;
    send(12);
    rd(`EEMI_OFF_POS);
    chk(rd_d, 32'h00000000);
    // Pulse and direction, reverse; mode set before the model switches
    wr(`EEMI_OFF_CTRL, 32'h00000003);
    pd <= 1'b1;
    send(5);
    chk(ref_pos, 32'hFFFFFFF6);
    pd <= 1'b0;
    via_gen <= 1'b1;
    wr(`EEMI_OFF_CTRL, 32'h00000005);
    rev <= 1'b0;
    send(7);
    chk(ref_pos, 32'h00000004);
    chk(eoe, 1'b0);
    rd(`EEMI_OFF_STAT);
    chk(rd_d, 32'h00000000);
    // Resolver emulation, 16 lines: quarter turn gives 16 edges
    via_gen <= 1'b0;
    wr(`EEMI_OFF_RES, 32'h00000010);
    wr(`EEMI_OFF_CTRL, 32'h00000008);
    repeat (10) @(posedge aclk);
    chk(er, 1'b1);
    e0 = edges;
    motor_pos <= 16'h4000;
    repeat (3000) @(posedge aclk);
    chk(edges - e0, 32'h00000010);
    chk(eoe, 1'b1);
    motor_pos <= 16'h0000;
    repeat (3000) @(posedge aclk);
    chk(edges, e0);
    rd(`EEMI_OFF_STAT);
    chk(rd_d, 32'h00000005);
    // Incremental feedback of 8 lines, no zero mark: quarter turn gives 8 edges (a half turn is signed-ambiguous)
    wr(`EEMI_OFF_CTRL, 32'h00000010);
    e0 = edges;
    motor_pos <= 16'h4000;
    repeat (3000) @(posedge aclk);
    chk(edges - e0, 32'h00000008);
    motor_pos <= 16'h0000;
    repeat (3000) @(posedge aclk);
    chk(er, 1'b0);
    // Reset in mid-run clears the outputs
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(eoe, 1'b0);
    chk(ref_pos, 32'h00000000);
    aresetn <= 1'b1;
    rd(`EEMI_OFF_CTRL);
    chk(rd_d, `EEMI_CTRL_RST);
    rd(`EEMI_OFF_RES);
    chk(rd_d, 32'h00000800);
    print_verdict();
  end
endmodule // eemi_top_bench
